// *** hdl/psb_pkg.sv ***
// constants shared by the burst port and its storage array
// assumes a 25 MHz system clock and a host-driven burst clock
package psb_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int MAX_BURST_NS  = 2500;
    // longest time: rounds down
    localparam int MAX_BURST_CYC = MAX_BURST_NS / CLK_PERIOD_NS;
    localparam int STOP_GAP_NS   = 12;
    // least time: rounds up
    localparam int STOP_GAP_CYC  =
        (STOP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // geometry and defaults
    // ------------------------------------------------------------------
    localparam int DEF_LATENCY   = 5;
    localparam int DEF_BURST_LEN = 4;
    localparam int DEF_ADDR_W    = 22;
    localparam int DATA_W        = 16;
    localparam int LANES         = 2;
    localparam int LANE_W        = 8;
    localparam int CNT_W         = 8;

    // ------------------------------------------------------------------
    // pin levels
    // ------------------------------------------------------------------
    localparam logic       WAIT_READY  = 1'b1;
    localparam logic       WAIT_BUSY   = 1'b0;
    localparam logic       OE_ON       = 1'b0;
    localparam logic       OE_OFF      = 1'b1;
    localparam logic [1:0] BOTH_MASKED = 2'h3;

    typedef enum logic [1:0] {
        PSB_IDLE,
        PSB_LAT,
        PSB_DATA,
        PSB_HOLD
    } psb_state_type;
endpackage

// *** hdl/psb_mem_if.sv ***
// word port between the burst engine and its storage array
// assumes both ends run on the burst clock
`timescale 1ns/1ns
interface psb_mem_if #(
    parameter int AW = 22
);
    logic                        wr_en;
    logic [AW-1:0]               addr;
    logic [psb_pkg::DATA_W-1:0]  wdata;
    logic [psb_pkg::LANES-1:0]   lane_en;
    logic [psb_pkg::DATA_W-1:0]  rdata;

    modport ctrl (output wr_en, addr, wdata, lane_en, input rdata);
    modport mem  (input wr_en, addr, wdata, lane_en, output rdata);
endinterface

// *** hdl/psb_mem_array.sv ***
// storage array of the burst port, byte-lane writes
// assumes clk and clock enable are the burst-domain ones
`timescale 1ns/1ns
module psb_mem_array #(
    parameter int AW = psb_pkg::DEF_ADDR_W
) (
    input  wire logic clk_in,      // burst clock
    input  wire logic ce_in,       // clock enable
    psb_mem_if.mem    port         // word port
);
    logic [psb_pkg::DATA_W-1:0] mem_q [0:(1<<AW)-1];

    assign port.rdata = mem_q[port.addr];

    always_ff @(posedge clk_in) begin
        if (ce_in && port.wr_en) begin
            for (int i = 0; i < psb_pkg::LANES; i++) begin
                if (port.lane_en[i]) begin
                    mem_q[port.addr][i*psb_pkg::LANE_W +: psb_pkg::LANE_W]
                        <= port.wdata[i*psb_pkg::LANE_W +: psb_pkg::LANE_W];
                end
            end
        end
    end
endmodule // psb_mem_array

// *** hdl/psb_port.sv ***
// synchronous burst port of a 16-bit pseudo-static memory
// assumes the host drives the burst clock and all strobes; pin
// enables are resolved into wires by the surroundings
//
// Notes on behaviour
// - wait goes not-ready at burst start
// - wait goes ready at latency minus one
// - wait floats while chip select high
// - burst starts at first edge, strobe low
// - both byte enables high skip write
// - new strobe with select low restarts burst
// - chip select high stops burst
// - halted clock freezes burst read
// - pending word first after clock resumes
// - suspended read floats when oe high
// - suspended read with oe low holds data
`timescale 1ns/1ns
module psb_port #(
    parameter int AW        = psb_pkg::DEF_ADDR_W,
    parameter int LATENCY   = psb_pkg::DEF_LATENCY,
    parameter int BURST_LEN = psb_pkg::DEF_BURST_LEN
) (
    input  wire logic                       clk_in,            // system
    input  wire logic                       rst_in,            // sync rst
    input  wire logic                       ce_in,             // enable
    input  wire logic                       burst_clk_in,      // link clk
    input  wire logic                       cs_n_in,           // select
    input  wire logic                       address_valid_n_in,// strobe
    input  wire logic                       we_n_in,           // write
    input  wire logic                       oe_n_in,           // out en
    input  wire logic                       upper_byte_enable_n_in, // ub
    input  wire logic                       lower_byte_enable_n_in, // lb
    input  wire logic [AW-1:0]              addr_in,           // address
    input  wire logic [psb_pkg::DATA_W-1:0] dq_in,             // data in
    output logic      [psb_pkg::DATA_W-1:0] dq_out,            // data out
    output logic                            dq_oe_n_out,       // dq en
    output logic                            wait_out,          // wait
    output logic                            wait_oe_n_out,     // wait en
    output logic                            burst_overrun_out, // too long
    output logic                            stop_storm_out     // stops
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic beat_masked(input logic [1:0] be_n);
        return be_n == psb_pkg::BOTH_MASKED;
    endfunction

    localparam logic [psb_pkg::CNT_W-1:0] WAIT_AT =
        psb_pkg::CNT_W'(LATENCY - 2);
    localparam logic [psb_pkg::CNT_W-1:0] DATA_AT =
        psb_pkg::CNT_W'(LATENCY - 1);
    localparam logic [psb_pkg::CNT_W-1:0] LAST_BEAT =
        psb_pkg::CNT_W'(BURST_LEN - 1);
    localparam logic [psb_pkg::CNT_W-1:0] RUN_MAX =
        psb_pkg::CNT_W'(psb_pkg::MAX_BURST_CYC);
    localparam logic [psb_pkg::CNT_W-1:0] CNT_ONE = psb_pkg::CNT_W'(1);

    // ------------------------------------------------------------------
    // reset and enable into the burst domain
    // ------------------------------------------------------------------
    logic lrst_s1_q, lrst_q, lce_s1_q, lce_q;

    always_ff @(posedge burst_clk_in) begin
        lrst_s1_q <= rst_in;
        lrst_q    <= lrst_s1_q;
        lce_s1_q  <= ce_in;
        lce_q     <= lce_s1_q;
    end

    // ------------------------------------------------------------------
    // burst engine (burst clock)
    // ------------------------------------------------------------------
    psb_pkg::psb_state_type     state_q;
    logic [psb_pkg::CNT_W-1:0]  cnt_q, beat_q;
    logic [AW-1:0]              addr_q;
    logic                       write_q, adv_low_q, rd_drive_q;
    logic                       act_q, done_tgl_q, stop_tgl_q;
    logic [psb_pkg::DATA_W-1:0] dq_q;
    logic                       wait_q;
    logic                       start, beat, last;
    logic [1:0]                 be_n;

    psb_mem_if #(.AW(AW)) mem_if ();

    assign be_n  = {upper_byte_enable_n_in, lower_byte_enable_n_in};
    assign start = !cs_n_in && !address_valid_n_in && !adv_low_q;
    assign beat  = (state_q == psb_pkg::PSB_LAT && cnt_q == DATA_AT)
                || state_q == psb_pkg::PSB_DATA;
    assign last  = beat && (state_q == psb_pkg::PSB_DATA)
                && beat_q == LAST_BEAT;

    assign mem_if.addr    = addr_q;
    assign mem_if.wdata   = dq_in;
    assign mem_if.lane_en = ~be_n;
    assign mem_if.wr_en   = beat && write_q && !cs_n_in && !start
                         && !beat_masked(be_n);

    psb_mem_array #(.AW(AW)) u_mem (
        .clk_in (burst_clk_in),
        .ce_in  (lce_q),
        .port   (mem_if.mem)
    );

    always_ff @(posedge burst_clk_in) begin
        if (lrst_q) begin
            adv_low_q <= 1'b0;
        end else if (lce_q) begin
            adv_low_q <= !cs_n_in && !address_valid_n_in;
        end
    end

    // state, counters and address
    always_ff @(posedge burst_clk_in) begin
        if (lrst_q) begin
            state_q <= psb_pkg::PSB_IDLE;
            cnt_q   <= '0;
            beat_q  <= '0;
            addr_q  <= '0;
            write_q <= 1'b0;
        end else if (lce_q) begin
            if (cs_n_in) begin
                state_q <= psb_pkg::PSB_IDLE;
            end else if (start) begin
                state_q <= psb_pkg::PSB_LAT;
                cnt_q   <= CNT_ONE;
                beat_q  <= '0;
                addr_q  <= addr_in;
                write_q <= !we_n_in;
            end else begin
                case (state_q)
                    psb_pkg::PSB_LAT: begin
                        cnt_q <= cnt_q + CNT_ONE;
                        if (beat) begin
                            state_q <= psb_pkg::PSB_DATA;
                            beat_q  <= CNT_ONE;
                            addr_q  <= addr_q + AW'(1);
                        end
                    end
                    psb_pkg::PSB_DATA: begin
                        beat_q <= beat_q + CNT_ONE;
                        addr_q <= addr_q + AW'(1);
                        if (last) begin
                            state_q <= write_q ? psb_pkg::PSB_IDLE
                                               : psb_pkg::PSB_HOLD;
                        end
                    end
                    psb_pkg::PSB_HOLD: state_q <= psb_pkg::PSB_HOLD;
                    psb_pkg::PSB_IDLE: state_q <= psb_pkg::PSB_IDLE;
                    default: state_q <= psb_pkg::PSB_IDLE;
                endcase
            end
        end
    end

    // read data and drive level
    // no burst edge, no word advance
    always_ff @(posedge burst_clk_in) begin
        if (lrst_q) begin
            dq_q       <= '0;
            rd_drive_q <= 1'b0;
        end else if (lce_q) begin
            if (cs_n_in || start) begin
                rd_drive_q <= 1'b0;
            // word advances only on a beat
            end else if (beat && !write_q) begin
                dq_q       <= mem_if.rdata;
                rd_drive_q <= 1'b1;
            end
        end
    end

    // wait pin level
    always_ff @(posedge burst_clk_in) begin
        if (lrst_q) begin
            wait_q <= psb_pkg::WAIT_BUSY;
        // not ready at deselect or strobe
        end else if (lce_q) begin
            if (cs_n_in || start) begin
                wait_q <= psb_pkg::WAIT_BUSY;
            end else if (state_q == psb_pkg::PSB_LAT && cnt_q == WAIT_AT) begin
                wait_q <= psb_pkg::WAIT_READY;
            end
        end
    end

    // activity level and end events for the monitor
    always_ff @(posedge burst_clk_in) begin
        if (lrst_q) begin
            act_q      <= 1'b0;
            done_tgl_q <= 1'b0;
            stop_tgl_q <= 1'b0;
        end else if (lce_q) begin
            act_q <= !cs_n_in && (start || state_q == psb_pkg::PSB_LAT
                  || (state_q == psb_pkg::PSB_DATA && !last));
            if (!cs_n_in && last) begin
                done_tgl_q <= !done_tgl_q;
            end
            if (cs_n_in && (state_q == psb_pkg::PSB_LAT
                         || state_q == psb_pkg::PSB_DATA)) begin
                stop_tgl_q <= !stop_tgl_q;
            end
        end
    end

    assign dq_out   = dq_q;
    assign wait_out = wait_q;

    // ------------------------------------------------------------------
    // pin enables and burst monitor (system clock)
    // ------------------------------------------------------------------
    logic cs_s1_q, cs_s_q, oe_s1_q, oe_s_q, rd_s1_q, rd_s_q;
    logic act_s1_q, act_s_q;
    logic [2:0] done_s_q, stop_s_q;
    logic dq_oe_n_q, wait_oe_n_q, overrun_q, storm_q, storm_run_q;
    logic [psb_pkg::CNT_W-1:0] run_cnt_q, storm_cnt_q;
    logic done_ev, stop_ev;

    always_ff @(posedge clk_in) begin
        cs_s1_q  <= cs_n_in;
        cs_s_q   <= cs_s1_q;
        oe_s1_q  <= oe_n_in;
        oe_s_q   <= oe_s1_q;
        rd_s1_q  <= rd_drive_q;
        rd_s_q   <= rd_s1_q;
        act_s1_q <= act_q;
        act_s_q  <= act_s1_q;
        done_s_q <= {done_s_q[1:0], done_tgl_q};
        stop_s_q <= {stop_s_q[1:0], stop_tgl_q};
    end

    assign done_ev = done_s_q[2] ^ done_s_q[1];
    assign stop_ev = stop_s_q[2] ^ stop_s_q[1];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dq_oe_n_q   <= psb_pkg::OE_OFF;
            wait_oe_n_q <= psb_pkg::OE_OFF;
        end else if (ce_in) begin
            wait_oe_n_q <= cs_s_q ? psb_pkg::OE_OFF : psb_pkg::OE_ON;
            // oe high floats, oe low drives a read word while selected
            dq_oe_n_q   <= (!cs_s_q && !oe_s_q && rd_s_q)
                         ? psb_pkg::OE_ON : psb_pkg::OE_OFF;
        end
    end

    // overlong burst and repeated stop flags
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            run_cnt_q   <= '0;
            overrun_q   <= 1'b0;
            storm_cnt_q <= '0;
            storm_run_q <= 1'b0;
            storm_q     <= 1'b0;
        end else if (ce_in) begin
            if (!act_s_q) begin
                run_cnt_q <= '0;
            end else if (run_cnt_q != RUN_MAX) begin
                run_cnt_q <= run_cnt_q + CNT_ONE;
            end
            overrun_q <= act_s_q && run_cnt_q == RUN_MAX;
            // stop in the same cycle as a completion wins
            if (done_ev && !stop_ev) begin
                storm_run_q <= 1'b0;
                storm_cnt_q <= '0;
            end else if (stop_ev) begin
                storm_run_q <= 1'b1;
            end else if (storm_run_q && storm_cnt_q != RUN_MAX) begin
                storm_cnt_q <= storm_cnt_q + CNT_ONE;
            end
            storm_q <= storm_run_q && storm_cnt_q == RUN_MAX;
        end
    end

    assign dq_oe_n_out       = dq_oe_n_q;
    assign wait_oe_n_out     = wait_oe_n_q;
    assign burst_overrun_out = overrun_q;
    assign stop_storm_out    = storm_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_wait_busy;
        @(posedge burst_clk_in) disable iff (lrst_q)
        (lce_q && start) |=> (wait_q == psb_pkg::WAIT_BUSY
                              && state_q == psb_pkg::PSB_LAT);
    endproperty
    a_wait_busy: assert property (p_wait_busy)
        else $error("wait not busy after burst start");

    property p_wait_ready;
        @(posedge burst_clk_in) disable iff (lrst_q)
        $rose(wait_q) |-> ($past(state_q) == psb_pkg::PSB_LAT
                           && $past(cnt_q) == WAIT_AT);
    endproperty
    a_wait_ready: assert property (p_wait_ready)
        else $error("wait ready at wrong clock");

    property p_wait_float;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && cs_s_q) |=> wait_oe_n_q == psb_pkg::OE_OFF;
    endproperty
    a_wait_float: assert property (p_wait_float)
        else $error("wait driven while deselected");

    property p_first_edge;
        @(posedge burst_clk_in) disable iff (lrst_q)
        (lce_q && state_q == psb_pkg::PSB_LAT && !cs_n_in
         && !address_valid_n_in && $past(lce_q))
        |=> cnt_q == $past(cnt_q) + CNT_ONE;
    endproperty
    a_first_edge: assert property (p_first_edge)
        else $error("held strobe restarted the burst");

    property p_mask;
        @(posedge burst_clk_in) disable iff (lrst_q)
        (beat && write_q && beat_masked(be_n)) |-> !mem_if.wr_en;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked beat was written");

    property p_rechain;
        @(posedge burst_clk_in) disable iff (lrst_q)
        (lce_q && start && state_q == psb_pkg::PSB_HOLD)
        |=> (state_q == psb_pkg::PSB_LAT && !rd_drive_q);
    endproperty
    a_rechain: assert property (p_rechain)
        else $error("held-select burst not accepted");

    property p_stop;
        @(posedge burst_clk_in) disable iff (lrst_q)
        (lce_q && cs_n_in) |=> (state_q == psb_pkg::PSB_IDLE
                                && !rd_drive_q && !act_q);
    endproperty
    a_stop: assert property (p_stop)
        else $error("burst not stopped by deselect");

    property p_word_hold;
        @(posedge burst_clk_in) disable iff (lrst_q)
        (dq_q != $past(dq_q)) |-> ($past(beat) && !$past(write_q));
    endproperty
    a_word_hold: assert property (p_word_hold)
        else $error("read word moved without a beat");

    property p_oe_float;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && oe_s_q) |=> dq_oe_n_q == psb_pkg::OE_OFF;
    endproperty
    a_oe_float: assert property (p_oe_float)
        else $error("data driven with oe high");

    property p_oe_drive;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && rd_s_q && !cs_s_q && !oe_s_q)
        |=> dq_oe_n_q == psb_pkg::OE_ON;
    endproperty
    a_oe_drive: assert property (p_oe_drive)
        else $error("suspended word not driven");

    property p_sustain;
        @(posedge burst_clk_in) disable iff (lrst_q)
        (state_q == psb_pkg::PSB_HOLD && !cs_n_in && !start)
        |=> ($stable(dq_q) && rd_drive_q);
    endproperty
    a_sustain: assert property (p_sustain)
        else $error("last word not sustained");
endmodule // psb_port

// *** sim/psb_host.sv ***
// host controller model: burst clock, select, strobe, lanes, data
// assumes the bench calls one task at a time; clock stands still between
`timescale 1ns/1ns
module psb_host #(
    parameter int AW = 6
) (
    output logic          bclk_out,  // burst clock
    output logic          cs_n_out,  // chip select
    output logic          adv_n_out, // address strobe
    output logic          we_n_out,  // write select
    output logic          ub_n_out,  // upper lane
    output logic          lb_n_out,  // lower lane
    output logic [AW-1:0] addr_out,  // start address
    output logic [15:0]   dq_out     // write data
);
    initial begin
        bclk_out  = 1'b0;
        cs_n_out  = 1'b1;
        adv_n_out = 1'b1;
        we_n_out  = 1'b1;
        ub_n_out  = 1'b1;
        lb_n_out  = 1'b1;
        addr_out  = '0;
        dq_out    = 16'h0000;
    end

    // ------------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------------
    // signals change only after a falling edge
    task automatic tick(input int n);
        repeat (n) begin
            #7 bclk_out = 1'b1;
            #8 bclk_out = 1'b0;
        end
    endtask

    // new strobe, select may stay low
    task automatic start(input logic we_n, input logic [AW-1:0] a,
                         input int hold);
        cs_n_out  = 1'b0;
        adv_n_out = 1'b0;
        we_n_out  = we_n;
        addr_out  = a;
        tick(hold);
        adv_n_out = 1'b1;
        addr_out  = ~a;
        we_n_out  = ~we_n;
    endtask

    // both lanes high masks the beat
    task automatic beat(input logic [15:0] d, input logic [1:0] lanes_n);
        dq_out                 = d;
        {ub_n_out, lb_n_out}   = lanes_n;
        tick(1);
    endtask

    // short bursts, gap after end or stop
    task automatic stop();
        cs_n_out  = 1'b1;
        adv_n_out = 1'b1;
        dq_out    = ~dq_out;
        tick(2);
    endtask
endmodule // psb_host

// *** sim/tb.sv ***
// self-checking bench of the burst port with a host model
// assumes the port's pin enables are resolved on the system clock
`timescale 1ns/1ns
module tb;
    localparam int AW  = 6;
    localparam int LAT = psb_pkg::DEF_LATENCY;

    typedef struct {
        logic [AW-1:0] a;
        logic [15:0]   base;
        int            mb;
        logic [1:0]    l0;
        int            n;
    } psb_row_type;

    logic          clk_in;
    logic          rst_in;
    logic          oe_n, ce;
    logic          bclk, cs_n, adv_n, we_n, ub_n, lb_n;
    logic [AW-1:0] haddr;
    logic [15:0]   hdq;
    logic [15:0]   dq_out;
    logic          dq_oe_n_out, wait_out, wait_oe_n_out;
    logic          burst_overrun_out, stop_storm_out;
    logic [15:0]   mem_m [64];
    int            bad_count;
    int            total_checks;
    psb_row_type   rows [4] = '{
        '{6'h10, 16'hA000, 9, 2'h0, 4}, '{6'h10, 16'hB000, 2, 2'h2, 4},
        '{6'h3C, 16'hC3C0, 9, 2'h0, 4}, '{6'h10, 16'hD000, 9, 2'h0, 2}};

    always #20 clk_in = ~clk_in;

    psb_host #(.AW(AW)) host (.bclk_out(bclk), .cs_n_out(cs_n),
        .adv_n_out(adv_n), .we_n_out(we_n), .ub_n_out(ub_n),
        .lb_n_out(lb_n), .addr_out(haddr), .dq_out(hdq));

    psb_port #(.AW(AW)) DUT (.clk_in(clk_in), .rst_in(rst_in),
        .ce_in(ce), .burst_clk_in(bclk), .cs_n_in(cs_n),
        .address_valid_n_in(adv_n), .we_n_in(we_n), .oe_n_in(oe_n),
        .upper_byte_enable_n_in(ub_n), .lower_byte_enable_n_in(lb_n),
        .addr_in(haddr), .dq_in(hdq), .dq_out(dq_out),
        .dq_oe_n_out(dq_oe_n_out), .wait_out(wait_out),
        .wait_oe_n_out(wait_oe_n_out),
        .burst_overrun_out(burst_overrun_out),
        .stop_storm_out(stop_storm_out));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic clks(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic wr(input psb_row_type r);
        int         i;
        logic [15:0] d;
        logic [1:0]  ln;
        host.start(1'b0, r.a, 1);
        host.tick(LAT - 2);
        for (i = 0; i < r.n; i++) begin
            d  = r.base + 16'(i);
            ln = (i == r.mb) ? psb_pkg::BOTH_MASKED :
                 (i == 0) ? r.l0 : 2'h0;
            host.beat(d, ln);
            if (!ln[1]) mem_m[r.a + i][15:8] = d[15:8];
            if (!ln[0]) mem_m[r.a + i][7:0] = d[7:0];
        end
        host.stop();
    endtask

    task automatic rd(input logic [AW-1:0] a, input int hold);
        int i;
        host.start(1'b1, a, hold);
        chk(wait_out, psb_pkg::WAIT_BUSY);
        host.tick(LAT - 1 - hold);
        chk(wait_out, psb_pkg::WAIT_READY);
        for (i = 0; i < 4; i++) begin
            host.tick(1);
            chk(dq_out, mem_m[a + i]);
        end
        host.tick(12);
        chk(dq_out, mem_m[a + 3]);
        chk(dq_oe_n_out, 1'b0);
        chk(wait_oe_n_out, 1'b0);
        host.stop();
        clks(4);
        chk(wait_oe_n_out, 1'b1);
        chk(dq_oe_n_out, 1'b1);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        #50000;
        bad_count++;
        print_verdict();
    end

    initial begin
        clk_in       = 1'b0;
        rst_in       = 1'b1;
        oe_n         = 1'b0;
        ce           = 1'b1;
        bad_count    = 0;
        total_checks = 0;
        fork
            clks(10);
            host.tick(27);
        join
        chk(wait_oe_n_out, 1'b1);
        chk(dq_oe_n_out, 1'b1);
        chk(burst_overrun_out, 1'b0);
        chk(stop_storm_out, 1'b0);
        @(negedge clk_in);
        rst_in = 1'b0;
        host.tick(6);
        clks(3);
        $display("test reset done");
        for (int r = 0; r < 4; r++) begin
            wr(rows[r]);
            rd(rows[r].a, 1);
            $display("test row %0d done", r);
        end
        // held strobe counts from first edge
        rd(6'h3C, 2);
        $display("test held strobe done");
        // restart with select held low once the last beat has gone
        host.start(1'b1, 6'h10, 1);
        host.tick(LAT + 2);
        host.start(1'b1, 6'h3C, 1);
        chk(wait_out, psb_pkg::WAIT_BUSY);
        host.tick(LAT - 1);
        chk(dq_out, mem_m[6'h3C]);
        host.stop();
        clks(4);
        $display("test chained burst done");
        host.start(1'b1, 6'h10, 1);
        host.tick(LAT - 1);
        host.stop();
        chk(dq_out, mem_m[6'h10]);
        chk(wait_out, psb_pkg::WAIT_BUSY);
        clks(4);
        rd(6'h10, 1);
        $display("test read stop done");
        // repeated stops raise the storm flag, a full burst clears it
        chk(stop_storm_out, 1'b0);
        repeat (6) begin
            host.start(1'b1, 6'h10, 1);
            host.tick(2);
            host.stop();
            clks(12);
        end
        chk(stop_storm_out, 1'b1);
        rd(6'h3C, 1);
        chk(stop_storm_out, 1'b0);
        $display("test repeated stop done");
        host.start(1'b1, 6'h3C, 1);
        host.tick(LAT - 1);
        clks(70);
        chk(dq_out, mem_m[6'h3C]);
        chk(dq_oe_n_out, 1'b0);
        chk(burst_overrun_out, 1'b1);
        oe_n = 1'b1;
        clks(4);
        chk(dq_oe_n_out, 1'b1);
        oe_n = 1'b0;
        clks(4);
        chk(dq_oe_n_out, 1'b0);
        chk(dq_out, mem_m[6'h3C]);
        host.tick(1);
        chk(dq_out, mem_m[6'h3D]);
        host.stop();
        clks(6);
        chk(burst_overrun_out, 1'b0);
        $display("test suspend done");
        // clock enable low freezes both domains
        ce = 1'b0;
        host.tick(3);
        host.start(1'b1, 6'h10, 1);
        host.tick(LAT + 2);
        clks(4);
        chk(wait_oe_n_out, 1'b1);
        chk(wait_out, psb_pkg::WAIT_BUSY);
        chk(dq_oe_n_out, 1'b1);
        host.stop();
        clks(1);
        ce = 1'b1;
        host.tick(3);
        rd(6'h10, 1);
        $display("test clock enable done");
        print_verdict();
    end
endmodule // tb
